/* rtl/adc_seq_pkg.sv */
package adc_seq_pkg;

	// register indexes on the plain port
	localparam logic [2:0] CTRL_ONE_ADDR   = 3'h0;
	localparam logic [2:0] CTRL_TWO_ADDR   = 3'h1;
	localparam logic [2:0] PIN_ENABLE_ADDR = 3'h2;
	localparam logic [2:0] IRQ_CTRL_ADDR   = 3'h3;
	localparam logic [2:0] RESULT_LO_ADDR  = 3'h4;
	localparam logic [2:0] RESULT_HI_ADDR  = 3'h5;

	// control one fields
	localparam int START_BIT   = 7;
	localparam int PEND_BIT    = 6;
	localparam int POWER_BIT   = 5;
	localparam int CH_LO_MSB   = 1;
	// control two fields
	localparam int CH_HI_BIT   = 7;
	localparam int REF_BIT     = 3;
	localparam int DIV_MSB     = 2;
	// irq control fields
	localparam int GIE_BIT     = 0;
	localparam int AIE_BIT     = 1;
	localparam int AIF_BIT     = 2;

	// reset values: pins analog, converter off
	localparam logic [7:0] CTRL_ONE_RST   = 8'h20;
	localparam logic [7:0] CTRL_TWO_RST   = 8'h00;
	localparam logic [3:0] PIN_ENABLE_RST = 4'hF;

	localparam int          CONV_CLOCKS = 16;
	localparam logic [2:0]  DIV_UNDEF   = 3'h7;
	localparam int          RESULT_W    = 12;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

	typedef enum logic [1:0] {
		IDLE,
		ARMED,
		CONVERT
	} conv_state_e;

endpackage

/* rtl/adc_conversion_sequencer.sv */
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Function
// - converter powered only while power-off clear
// - channel select split over two registers
// - each pin enable makes pin analog
// - interrupt needs global and converter enable
// - start rise resets, fall launches conversion
// - pending flag high during conversion, low after
// - result readable from low and high bytes
// - conversion lasts sixteen converter clocks
// - conversion runs without stalling cpu
// - result is 12-bit unsigned code
// - one step is reference over 4096
// - transitions half step below nominal
// - interrupt only when enabled and stack free; no stack check here, it is left to the cpu
// - irq flag writable, cleared by software
// - divider codes give divide 1 to 64; code 7 gives no converter clock, so the conversion never ends
// - completion sets irq flag always
module adc_conversion_sequencer
	import adc_seq_pkg::*;
#(
	parameter int RES_W = RESULT_W
) (
	input  wire logic                MCLK,
	input  wire logic                RST,
	input  wire logic [2:0]          ADDR,
	input  wire logic [7:0]          WDATA,
	input  wire logic                WR,
	input  wire logic                RD,
	output logic      [7:0]          RDATA,
	input  wire logic [RES_W-1:0]    SAR_CODE,
	output logic      [2:0]          CHANNEL,
	output logic      [3:0]          PIN_ANALOG,
	output logic                     POWER_ON,
	output logic                     REF_EXT,
	output logic                     SAR_RESET,
	output logic                     SAR_CLK_EN,
	output logic                     CONV_BUSY,
	output logic                     IRQ
);

	if (RES_W != 12) begin : g_bad_width
		$error("result width must be 12");
	end

	bus_req_s req;
	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	logic [7:0]       ctrl_one_reg, ctrl_one_next;
	logic [7:0]       ctrl_two_reg, ctrl_two_next;
	logic [3:0]       pins_reg, pins_next;
	logic             gie_reg, gie_next;
	logic             aie_reg, aie_next;
	logic             aif_reg, aif_next;
	logic [11:0]      result_reg, result_next;
	logic [7:0]       rdata_reg, rdata_next;
	conv_state_e      state_reg, state_next;
	logic [6:0]       div_cnt_reg, div_cnt_next;
	logic [4:0]       tick_cnt_reg, tick_cnt_next;
	logic             sar_rst_reg, sar_rst_next;
	logic             clk_en_reg, clk_en_next;
	logic             irq_reg, irq_next;
	logic             start_prev_reg;
	logic [10:0]      conv_len_reg, conv_len_next;

	logic             start_now;
	logic             start_rise;
	logic             start_fall;
	logic             powered;
	logic [6:0]       div_max;
	logic             adck;
	logic             done;

	////////////////////////////////////////////////////////////////////////
	// converter clock enable divider

	always_comb begin
		unique case (ctrl_two_reg[DIV_MSB:0])
			3'h0: div_max = 7'h00;
			3'h1: div_max = 7'h01;
			3'h2: div_max = 7'h03;
			3'h3: div_max = 7'h07;
			3'h4: div_max = 7'h0F;
			3'h5: div_max = 7'h1F;
			3'h6: div_max = 7'h3F;
			default: div_max = 7'h7F;
		endcase
	end

	assign powered    = ~ctrl_one_reg[POWER_BIT];
	assign adck       = (div_cnt_reg >= div_max) &&
		(ctrl_two_reg[DIV_MSB:0] != DIV_UNDEF);
	assign start_now  = ctrl_one_reg[START_BIT];
	assign start_rise = start_now & ~start_prev_reg;
	assign start_fall = ~start_now & start_prev_reg;
	assign done = (state_reg == CONVERT) && adck && powered &&
		!start_rise && (tick_cnt_reg == 5'(CONV_CLOCKS - 1));

	////////////////////////////////////////////////////////////////////////
	// conversion sequencer

	always_comb begin
		state_next    = state_reg;
		div_cnt_next  = div_cnt_reg;
		tick_cnt_next = tick_cnt_reg;
		sar_rst_next  = 1'b0;
		clk_en_next   = 1'b0;
		result_next   = result_reg;
		if (state_reg == CONVERT)
			div_cnt_next = adck ? 7'h00 : 7'(div_cnt_reg + 7'h01);
		unique case (state_reg)
			IDLE: begin
				if (start_rise && powered) begin
					state_next   = ARMED;
					sar_rst_next = 1'b1;
				end
			end
			ARMED: begin
				if (!powered)
					state_next = IDLE;
				else if (start_fall) begin
					state_next    = CONVERT;
					div_cnt_next  = 7'h00;
					tick_cnt_next = 5'h00;
				end
			end
			CONVERT: begin
				if (!powered) begin
					state_next = IDLE;
				end else if (start_rise) begin
					state_next   = ARMED;
					sar_rst_next = 1'b1;
				end else if (adck) begin
					clk_en_next   = 1'b1;
					tick_cnt_next = 5'(tick_cnt_reg + 5'h01);
					if (done) begin
						state_next  = IDLE;
						result_next = SAR_CODE;
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// register file

	always_comb begin
		ctrl_one_next = ctrl_one_reg;
		ctrl_two_next = ctrl_two_reg;
		pins_next     = pins_reg;
		gie_next      = gie_reg;
		aie_next      = aie_reg;
		aif_next      = aif_reg;
		rdata_next    = 8'h00;
		if (req.wr) begin
			unique case (req.addr)
				CTRL_ONE_ADDR:   ctrl_one_next = req.wdata;
				CTRL_TWO_ADDR:   ctrl_two_next = req.wdata;
				PIN_ENABLE_ADDR: pins_next = req.wdata[3:0];
				IRQ_CTRL_ADDR: begin
					gie_next = req.wdata[GIE_BIT];
					aie_next = req.wdata[AIE_BIT];
					aif_next = req.wdata[AIF_BIT];
				end
				default: ;
			endcase
		end
		if (done)
			aif_next = 1'b1; // set wins over clear
		if (req.rd) begin
			unique case (req.addr)
				CTRL_ONE_ADDR: begin
					rdata_next = ctrl_one_reg;
					rdata_next[PEND_BIT] = (state_reg != IDLE);
				end
				CTRL_TWO_ADDR:   rdata_next = ctrl_two_reg;
				PIN_ENABLE_ADDR: rdata_next = {4'h0, pins_reg};
				IRQ_CTRL_ADDR:
					rdata_next = {5'h00, aif_reg, aie_reg, gie_reg};
				RESULT_LO_ADDR:  rdata_next = result_reg[7:0];
				RESULT_HI_ADDR:  rdata_next = {4'h0, result_reg[11:8]};
				default:         rdata_next = 8'h00;
			endcase
		end
	end

	// interrupt request gated by both enables; stack check lies in the cpu
	assign irq_next = aif_reg & gie_reg & aie_reg;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ctrl_one_reg   <= CTRL_ONE_RST;
			ctrl_two_reg   <= CTRL_TWO_RST;
			pins_reg       <= PIN_ENABLE_RST;
			gie_reg        <= 1'b0;
			aie_reg        <= 1'b0;
			aif_reg        <= 1'b0;
			result_reg     <= 12'h000;
			rdata_reg      <= 8'h00;
			state_reg      <= IDLE;
			div_cnt_reg    <= 7'h00;
			tick_cnt_reg   <= 5'h00;
			sar_rst_reg    <= 1'b0;
			clk_en_reg     <= 1'b0;
			irq_reg        <= 1'b0;
			start_prev_reg <= 1'b0;
		end else begin
			ctrl_one_reg   <= ctrl_one_next;
			ctrl_two_reg   <= ctrl_two_next;
			pins_reg       <= pins_next;
			gie_reg        <= gie_next;
			aie_reg        <= aie_next;
			aif_reg        <= aif_next;
			result_reg     <= result_next;
			rdata_reg      <= rdata_next;
			state_reg      <= state_next;
			div_cnt_reg    <= div_cnt_next;
			tick_cnt_reg   <= tick_cnt_next;
			sar_rst_reg    <= sar_rst_next;
			clk_en_reg     <= clk_en_next;
			irq_reg        <= irq_next;
			start_prev_reg <= start_now;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	logic [2:0] chan_reg;
	logic [3:0] pin_out_reg;
	logic       pwr_reg;
	logic       ref_reg;
	logic       busy_reg;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			chan_reg    <= 3'h0;
			pin_out_reg <= PIN_ENABLE_RST;
			pwr_reg     <= 1'b0;
			ref_reg     <= 1'b0;
			busy_reg    <= 1'b0;
		end else begin
			chan_reg    <= {ctrl_two_next[CH_HI_BIT],
				ctrl_one_next[CH_LO_MSB:0]};
			pin_out_reg <= pins_next;
			pwr_reg     <= ~ctrl_one_next[POWER_BIT];
			ref_reg     <= ctrl_two_next[REF_BIT];
			busy_reg    <= (state_next == CONVERT);
		end
	end

	assign RDATA      = rdata_reg;
	assign CHANNEL    = chan_reg;
	assign PIN_ANALOG = pin_out_reg;
	assign POWER_ON   = pwr_reg;
	assign REF_EXT    = ref_reg;
	assign SAR_RESET  = sar_rst_reg;
	assign SAR_CLK_EN = clk_en_reg;
	assign CONV_BUSY  = busy_reg;
	assign IRQ        = irq_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	// cycles spent converting, for the length checks
	always_comb begin
		conv_len_next = 11'h000;
		if (state_reg == CONVERT)
			conv_len_next = 11'(conv_len_reg + 11'h001);
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			conv_len_reg <= 11'h000;
		else
			conv_len_reg <= conv_len_next;
	end

	sequence s_launch;
		state_reg == ARMED && start_fall && powered;
	endsequence

	sequence s_fast_div;
		ctrl_two_reg[DIV_MSB:0] == 3'h0 && !start_now;
	endsequence

	a_done_sets_flag: assert property (
		@(posedge MCLK) disable iff (RST) done |=> aif_reg)
		else $error("flag not set at completion");
	a_irq_gating: assert property (
		@(posedge MCLK) disable iff (RST)
		irq_reg |-> $past(aif_reg) && $past(gie_reg) && $past(aie_reg))
		else $error("interrupt without both enables");
	a_launch_busy: assert property (
		@(posedge MCLK) disable iff (RST) s_launch |=> busy_reg)
		else $error("busy not raised at launch");
	a_rise_resets: assert property (
		@(posedge MCLK) disable iff (RST)
		(start_rise && powered && state_reg != ARMED) |=> sar_rst_reg)
		else $error("rising start did not reset");
	a_sixteen_ticks: assert property (
		@(posedge MCLK) disable iff (RST)
		done |-> conv_len_reg == {div_max, 4'hF})
		else $error("conversion length wrong");
	a_fast_length: assert property (
		@(posedge MCLK) disable iff (RST)
		(s_launch and s_fast_div) ##16
		(conv_len_reg == 11'(CONV_CLOCKS - 1)) |=> state_reg != CONVERT)
		else $error("undivided conversion not sixteen cycles");
	a_power_off_idle: assert property (
		@(posedge MCLK) disable iff (RST)
		ctrl_one_reg[POWER_BIT] |=> state_reg == IDLE)
		else $error("conversion while powered off");
	a_result_low: assert property (
		@(posedge MCLK) disable iff (RST)
		(req.rd && req.addr == RESULT_LO_ADDR) |=>
		RDATA == 8'($past(result_reg)))
		else $error("low result byte wrong");
	a_pend_read: assert property (
		@(posedge MCLK) disable iff (RST)
		(req.rd && req.addr == CTRL_ONE_ADDR && state_reg == CONVERT) |=>
		RDATA[PEND_BIT])
		else $error("pending flag low during conversion");

endmodule // adc_conversion_sequencer

/* dv/sar_model.sv */
`timescale 1ns/1ps
module sar_model
	import adc_seq_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                busy,
	input  wire logic [RESULT_W-1:0] code_in,
	output logic      [RESULT_W-1:0] sar_code
);
	logic [RESULT_W-1:0] junk_reg = 12'h000;
	// comparator output is garbage outside a conversion
	always @(posedge mclk) begin
		junk_reg <= ~junk_reg ^ 12'h5A3;
	end
	assign sar_code = busy ? code_in : junk_reg;
endmodule // sar_model

/* dv/adc_conversion_sequencer_tb.sv */
`timescale 1ns/1ps
module adc_conversion_sequencer_tb
	import adc_seq_pkg::*;
;
	logic        mclk = 0, rst = 1, wr = 0, rd = 0, rd_q = 0;
	logic [2:0]  addr = 3'h0, channel;
	logic [7:0]  wdata = 8'h00, rdata;
	logic [11:0] code = 12'h000, sar;
	logic [3:0]  pins;
	logic        pwr, ref_ext, sar_rst, clk_en, busy, irq;
	logic [31:0] seed = 32'h85EF, p;
	logic [15:0] q[$];
	int          mismatches = 0, total_checks = 0, ticks, bcyc, rsts = 0;

	always #12.5 mclk = ~mclk;

	adc_conversion_sequencer i_adc_conversion_sequencer (
		.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .SAR_CODE(sar), .CHANNEL(channel),
		.PIN_ANALOG(pins), .POWER_ON(pwr), .REF_EXT(ref_ext),
		.SAR_RESET(sar_rst), .SAR_CLK_EN(clk_en), .CONV_BUSY(busy),
		.IRQ(irq));
	sar_model i_sar_model (.mclk(mclk), .busy(busy), .code_in(code),
		.sar_code(sar));

	////////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(logic [15:0] got, logic [15:0] exp, logic [15:0] m);
		total_checks++;
		if ((got & m) !== (exp & m)) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr_r(logic [2:0] a, logic [7:0] d);
		@(posedge mclk);
		wr <= 1; addr <= a; wdata <= d;
		@(posedge mclk);
		wr <= 0;
	endtask
	task rd_r(logic [2:0] a, logic [7:0] e, logic [7:0] m);
		@(posedge mclk);
		rd <= 1; addr <= a;
		q.push_back({m, e});
		@(posedge mclk);
		rd <= 0;
	endtask
	task settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task test_done();
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// read data checked from the oldest note
	always @(posedge mclk) begin
		rd_q <= rd;
		if (clk_en === 1'b1) ticks++;
		if (busy === 1'b1) bcyc++;
		if (sar_rst === 1'b1) rsts++;
	end
	always @(negedge mclk) begin
		if (rd_q && q.size() > 0) begin
			chk({8'h00, rdata}, {8'h00, q[0][7:0]}, {8'h00, q[0][15:8]});
			void'(q.pop_front());
		end
	end

	task conv(logic [2:0] d, logic [1:0] en);
		logic [11:0] c;
		int n;
		c = 12'(rnd());
		code <= c;
		wr_r(IRQ_CTRL_ADDR, {6'h00, en});
		wr_r(CTRL_TWO_ADDR, {5'h10, d});
		ticks = 0; bcyc = 0; rsts = 0;
		wr_r(CTRL_ONE_ADDR, 8'h82);
		wr_r(CTRL_ONE_ADDR, 8'h02);
		rd_r(CTRL_ONE_ADDR, 8'h40, 8'h60);
		chk(16'(rsts), 16'd1, 16'hFFFF);
		chk({13'h0, channel}, 16'h0006, 16'hFFFF);
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		settle();
		chk({15'h0, busy}, 16'h0000, 16'hFFFF);
		chk(16'(ticks), 16'd16, 16'hFFFF);
		chk(16'(bcyc), 16'(16 << d), 16'hFFFF);
		rd_r(CTRL_ONE_ADDR, 8'h00, 8'h40);
		rd_r(RESULT_LO_ADDR, c[7:0], 8'hFF);
		rd_r(RESULT_HI_ADDR, {4'h0, c[11:8]}, 8'hFF);
		rd_r(IRQ_CTRL_ADDR, {5'h01, en}, 8'h07);
		chk({15'h0, irq}, {15'h0, en == 2'b11}, 16'hFFFF);
		wr_r(IRQ_CTRL_ADDR, {6'h00, en});
		settle();
		chk({15'h0, irq}, 16'h0000, 16'hFFFF);
		rd_r(IRQ_CTRL_ADDR, {6'h00, en}, 8'h07);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 0;
		#1;
		chk({12'h0, pins}, 16'h000F, 16'hFFFF);
		chk({15'h0, pwr}, 16'h0000, 16'hFFFF);
		rd_r(CTRL_ONE_ADDR, CTRL_ONE_RST, 8'hE3);
		rd_r(PIN_ENABLE_ADDR, {4'h0, PIN_ENABLE_RST}, 8'h0F);
		rd_r(3'h6, 8'h00, 8'hFF);
		wr_r(CTRL_ONE_ADDR, 8'hA0);
		wr_r(CTRL_ONE_ADDR, 8'h20);
		settle();
		chk({15'h0, busy}, 16'h0000, 16'hFFFF);
		chk(16'(rsts), 16'h0000, 16'hFFFF);
		wr_r(CTRL_ONE_ADDR, 8'h02);
		repeat (8) @(posedge mclk);
		p = rnd();
		wr_r(PIN_ENABLE_ADDR, {4'h0, p[3:0]});
		wr_r(CTRL_TWO_ADDR, 8'h08);
		settle();
		chk({15'h0, pwr}, 16'h0001, 16'hFFFF);
		chk({12'h0, pins}, {12'h0, p[3:0]}, 16'hFFFF);
		chk({15'h0, ref_ext}, 16'h0001, 16'hFFFF);
		for (int d = 0; d < 7; d++)
			conv(3'(d), 2'(d));
		settle();
		test_done();
	end

	initial begin
		#200000;
		mismatches++;
		test_done();
	end
endmodule // adc_conversion_sequencer_tb
